// ### hdl/torque_flag_output_router.v
// Torque status flags, slot routing of status functions, APB registers and interrupt
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "torque_flag_defines.vh"

// Overview of operation
// - Limit flag low while reference exceeds limit
// - Limit flag works in every control mode
// - Reset slot codes carry neither torque flag
// - Slot one digit 3 carries limit flag
// - Slot two digit 3 carries limit flag
// - Slot three digit 3 carries limit flag
// - Digit codes 0 to 9 select one of ten functions; higher codes leave the slot off
// - Over flag low while torque exceeds threshold
// - Over flag waits configured detection time
// - Overtravel and excitation routed the same way
module torque_flag_output_router #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [1:0]  control_mode,
    input  wire [15:0] torque_reference,
    input  wire [15:0] motor_torque,
    input  wire        position_done_out,
    input  wire        speed_match_out,
    input  wire        rotating_out,
    input  wire        drive_ready,
    input  wire        brake_interlock_out,
    input  wire        index_pulse_out,
    input  wire        overtravel_out,
    input  wire        excitation_out,
    input  wire        home_done,
    output reg  [2:0]  slot_out_n,
    output reg         irq
);

    // Counter end point cut to the counter width on purpose
    localparam [31:0] MS_LAST = MS_CYCLES - 1;

    reg  [11:0] output_slot_select_q;
    reg  [15:0] torque_limit_q;
    reg  [15:0] torque_detect_threshold_q;
    reg  [15:0] torque_detect_time_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_mask_q;
    reg  [1:0]  irq_status_d;
    reg         limit_active_q;
    reg         over_active_q;
    reg         limit_prev_q;
    reg         over_prev_q;
    reg  [31:0] ms_count_q;
    reg  [15:0] ms_elapsed_q;
    reg  [31:0] rdata_d;
    reg         addr_ok_d;
    reg  [9:0]  fn_active;

    wire        access   = psel & penable;
    wire        commit   = access & pready;
    wire        wr_en    = commit & pwrite & ~pslverr;
    wire        above_th = motor_torque > torque_detect_threshold_q;
    wire        ms_tick  = (ms_count_q == MS_LAST);
    wire        wr_slot  = wr_en & (paddr == `ADDR_SLOT_SELECT);
    wire        wr_limit = wr_en & (paddr == `ADDR_TORQUE_LIMIT);
    wire        wr_thr   = wr_en & (paddr == `ADDR_DETECT_THRESHOLD);
    wire        wr_time  = wr_en & (paddr == `ADDR_DETECT_TIME);
    wire        wr_mask  = wr_en & (paddr == `ADDR_IRQ_MASK);
    wire        wr_clr   = wr_en & (paddr == `ADDR_IRQ_STATUS);
    wire [1:0]  flag_rise;

    // Edge detectors reset low like the flags, so no false edge after reset
    assign flag_rise[`IRQ_BIT_LIMIT] = limit_active_q & ~limit_prev_q;
    assign flag_rise[`IRQ_BIT_OVER]  = over_active_q & ~over_prev_q;

    // Limit flag, no mode gating
    // clamp compare
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            limit_active_q <= 1'b0;
        end
        else
        begin
            limit_active_q <= torque_reference > torque_limit_q;
        end
    end

    // Over flag rises only after a continuous run above threshold; drops at once
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ms_count_q    <= 32'h00000000;
            ms_elapsed_q  <= 16'h0000;
            over_active_q <= 1'b0;
        end
        else if (!above_th)
        begin
            ms_count_q    <= 32'h00000000;
            ms_elapsed_q  <= 16'h0000;
            over_active_q <= 1'b0;
        end
        else
        begin
            ms_count_q <= ms_tick ? 32'h00000000 : ms_count_q + 32'h00000001;
            if (ms_tick && ms_elapsed_q != 16'hFFFF)
            begin
                ms_elapsed_q <= ms_elapsed_q + 16'h0001;
            end
            if (ms_elapsed_q >= torque_detect_time_q)
            begin
                over_active_q <= 1'b1;
            end
        end
    end

    always @*
    begin
        fn_active    = 10'h000;
        fn_active[0] = (control_mode == `MODE_POSITION) ? position_done_out : speed_match_out;
        fn_active[1] = rotating_out;
        fn_active[2] = drive_ready;
        fn_active[3] = limit_active_q;
        fn_active[4] = brake_interlock_out;
        fn_active[5] = index_pulse_out;
        fn_active[6] = overtravel_out;
        fn_active[7] = excitation_out;
        fn_active[8] = home_done;
        fn_active[9] = over_active_q;
    end

    // Slot outputs are active low; an undefined code leaves the slot off
    genvar s;
    generate
        for (s = 0; s < 3; s = s + 1)
        begin : g_slot
            wire [3:0] code = output_slot_select_q[4*s+3:4*s];
            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    slot_out_n[s] <= 1'b1;
                end
                else
                begin
                    slot_out_n[s] <= (code <= `FN_TORQUE_OVER) ? ~fn_active[code] : 1'b1;
                end
            end
        end
    endgenerate

    // Rising flag edges latch; set beats a same-cycle clear
    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1)
        begin : g_irq
            always @*
            begin
                irq_status_d[b] = irq_status_q[b];
                if (wr_clr && pwdata[b])
                begin
                    irq_status_d[b] = 1'b0;
                end
                // A rise in the clear cycle is kept, not lost
                if (flag_rise[b])
                begin
                    irq_status_d[b] = 1'b1;
                end
            end
        end
    endgenerate

    always @*
    begin
        rdata_d   = 32'h00000000;
        addr_ok_d = 1'b1;
        case (paddr)
            `ADDR_SLOT_SELECT:      rdata_d[11:0] = output_slot_select_q;
            `ADDR_TORQUE_LIMIT:     rdata_d[15:0] = torque_limit_q;
            `ADDR_DETECT_THRESHOLD: rdata_d[15:0] = torque_detect_threshold_q;
            `ADDR_DETECT_TIME:      rdata_d[15:0] = torque_detect_time_q;
            `ADDR_FLAG_STATUS:      rdata_d[4:0]  = {~slot_out_n, over_active_q, limit_active_q};
            `ADDR_IRQ_STATUS:       rdata_d[1:0]  = irq_status_q;
            `ADDR_IRQ_MASK:         rdata_d[1:0]  = irq_mask_q;
            default:                addr_ok_d     = 1'b0;
        endcase
    end

    // One wait state: ready is raised in the second access cycle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~addr_ok_d;
            if (access && !pready && !pwrite)
            begin
                prdata <= rdata_d;
            end
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            output_slot_select_q <= `SLOT_SELECT_RESET;
        end
        else if (wr_slot)
        begin
            output_slot_select_q <= pwdata[11:0];
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            torque_limit_q <= `TORQUE_LIMIT_RESET;
        end
        else if (wr_limit)
        begin
            torque_limit_q <= pwdata[15:0];
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            torque_detect_threshold_q <= `THRESHOLD_RESET;
        end
        else if (wr_thr)
        begin
            torque_detect_threshold_q <= pwdata[15:0];
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            torque_detect_time_q <= `DETECT_TIME_RESET;
        end
        else if (wr_time)
        begin
            torque_detect_time_q <= pwdata[15:0];
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_q <= 2'h0;
        end
        else if (wr_mask)
        begin
            irq_mask_q <= pwdata[1:0];
        end
    end

    // Irq follows the next status so it lines up with the status bit
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_q <= 2'h0;
            limit_prev_q <= 1'b0;
            over_prev_q  <= 1'b0;
            irq          <= 1'b0;
        end
        else
        begin
            limit_prev_q <= limit_active_q;
            over_prev_q  <= over_active_q;
            irq_status_q <= irq_status_d;
            irq          <= |(irq_status_d & irq_mask_q);
        end
    end

endmodule // torque_flag_output_router

// ### hdl/torque_flag_defines.vh
// Register map, field layout, reset values and timing counts for the flag router
`ifndef TORQUE_FLAG_DEFINES_VH
`define TORQUE_FLAG_DEFINES_VH

`define ADDR_SLOT_SELECT      12'h000
`define ADDR_TORQUE_LIMIT     12'h004
`define ADDR_DETECT_THRESHOLD 12'h008
`define ADDR_DETECT_TIME      12'h00C
`define ADDR_FLAG_STATUS      12'h010
`define ADDR_IRQ_STATUS       12'h014
`define ADDR_IRQ_MASK         12'h018

`define SLOT_SELECT_RESET     12'h210
`define TORQUE_LIMIT_RESET    16'hFFFF
`define THRESHOLD_RESET       16'hFFFF
`define DETECT_TIME_RESET     16'h0000

`define FN_DONE_OR_MATCH      4'h0
`define FN_ROTATING           4'h1
`define FN_DRIVE_READY        4'h2
`define FN_TORQUE_LIMIT       4'h3
`define FN_BRAKE              4'h4
`define FN_INDEX_PULSE        4'h5
`define FN_OVERTRAVEL         4'h6
`define FN_EXCITATION         4'h7
`define FN_HOME               4'h8
`define FN_TORQUE_OVER        4'h9

`define MODE_SPEED            2'h0
`define MODE_TORQUE           2'h1
`define MODE_POSITION         2'h2

`define IRQ_BIT_LIMIT         0
`define IRQ_BIT_OVER          1

`define DETECT_TIME_MS        1
`define CLK_MHZ               100
`define MS_CYCLES             (`DETECT_TIME_MS * `CLK_MHZ * 1000)

`endif

// ### verif/torque_flag_props.sv
// Port checker for the torque flag router
`timescale 1ns/1ps
`include "torque_flag_defines.vh"
module torque_flag_props (
    input wire        mclk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire [15:0] torque_reference,
    input wire [2:0]  slot_out_n
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    reg  [11:0] sel_q;
    reg  [15:0] lim_q;
    wire        wr = psel & penable & pready & pwrite;
    wire        over_lim = torque_reference > lim_q;
    wire [2:0]  is3 = {sel_q[11:8] == 4'h3, sel_q[7:4] == 4'h3, sel_q[3:0] == 4'h3};
    wire [2:0]  hi = {sel_q[11:8] > 4'h9, sel_q[7:4] > 4'h9, sel_q[3:0] > 4'h9};
    // Mirror kept in step with the bus commit edge
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sel_q <= `SLOT_SELECT_RESET;
            lim_q <= `TORQUE_LIMIT_RESET;
        end
        else if (wr && paddr == `ADDR_SLOT_SELECT)
            sel_q <= pwdata[11:0];
        else if (wr && paddr == `ADDR_TORQUE_LIMIT)
            lim_q <= pwdata[15:0];
    end
    a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("no single wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_req: assert property (pready |-> psel && penable)
        else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr)
        else $error("unmapped access accepted");
    a_err_mapped: assert property (pready && paddr < 12'h01C && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_code_off: assert property (!$past(rst) |-> (~slot_out_n & $past(hi)) == 3'h0)
        else $error("unknown code drives slot");
    a_limit_slot: assert property (!$past(rst) && !$past(rst, 2) |->
        ((slot_out_n ^ {3{!$past(over_lim, 2)}}) & $past(is3)) == 3'h0)
        else $error("limit flag wrong on slot");
endmodule // torque_flag_props

// ### verif/host_reader.sv
// Host controller model reading the drive output slots
`timescale 1ns/1ps
module host_reader (
    input  wire [2:0] slot_out_n,
    output wire [2:0] slot_on
);
    // Low level is read as on
    assign slot_on = ~slot_out_n;
endmodule // host_reader

// ### verif/torque_flag_output_router_tb.sv
// Self-checking bench for the torque flag router
`timescale 1ns/1ps
`include "torque_flag_defines.vh"
module torque_flag_output_router_tb;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  control_mode = 2'h0;
    logic [15:0] torque_reference = 16'h0, motor_torque = 16'h0;
    logic [8:0]  fin = 9'h0;
    logic [2:0]  slot_out_n, slot_on;
    int          n_mismatch = 0, compares = 0, i, k;
    logic [31:0] rows [6] = '{32'h210_0_00A_5, 32'h210_2_00A_4, 32'h654_0_070_7,
                              32'h876_1_140_5, 32'hA93_0_1FF_0, 32'h021_0_004_1};
    torque_flag_output_router #(.MS_CYCLES(10)) u_dut (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .control_mode, .torque_reference, .motor_torque, .position_done_out(fin[0]),
        .speed_match_out(fin[1]), .rotating_out(fin[2]), .drive_ready(fin[3]),
        .brake_interlock_out(fin[4]), .index_pulse_out(fin[5]), .overtravel_out(fin[6]),
        .excitation_out(fin[7]), .home_done(fin[8]), .slot_out_n, .irq);
    host_reader u_host (.slot_out_n, .slot_on);
    always #5 mclk = ~mclk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        k = 0;
        do
            @(posedge mclk);
        while (!pready && ++k < 20);
        if (k == 20)
        begin
            n_mismatch++;
            stop_test;
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
            @(posedge mclk);
        end
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 0;
        apb(0, `ADDR_SLOT_SELECT, 0);
        chk(rd, 32'h210);
        apb(0, 12'h020, 0);
        chk({rd[30:0], err}, 32'h1);
        $display("reset test done");
        for (i = 0; i < 6; i++)
        begin
            apb(1, `ADDR_SLOT_SELECT, rows[i][31:20]);
            control_mode <= rows[i][17:16];
            fin <= rows[i][12:4];
            repeat (3) @(posedge mclk);
            chk(slot_on, rows[i][3:0]);
        end
        $display("routing rows done");
        apb(1, `ADDR_SLOT_SELECT, 32'h333);
        apb(1, `ADDR_TORQUE_LIMIT, 32'h1000);
        apb(1, `ADDR_IRQ_MASK, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            control_mode <= i[1:0];
            torque_reference <= 16'h1000;
            repeat (3) @(posedge mclk);
            chk(slot_on, 0);
            torque_reference <= 16'h1001;
            repeat (3) @(posedge mclk);
            chk({irq, slot_on}, 32'hF);
            apb(1, `ADDR_IRQ_STATUS, 32'h1);
            chk(irq, 0);
        end
        apb(1, `ADDR_IRQ_MASK, 0);
        torque_reference <= 16'h0;
        repeat (3) @(posedge mclk);
        torque_reference <= 16'hFFFF;
        repeat (3) @(posedge mclk);
        chk(irq, 0);
        apb(0, `ADDR_IRQ_STATUS, 0);
        chk(rd, 32'h1);
        $display("limit test done");
        apb(1, `ADDR_SLOT_SELECT, 32'h999);
        apb(1, `ADDR_DETECT_THRESHOLD, 32'h100);
        apb(1, `ADDR_DETECT_TIME, 32'h2);
        motor_torque <= 16'h101;
        repeat (12) @(posedge mclk);
        chk(slot_on, 0);
        repeat (20) @(posedge mclk);
        chk(slot_on, 7);
        motor_torque <= 16'h100;
        repeat (3) @(posedge mclk);
        chk(slot_on, 0);
        $display("over test done");
        apb(1, `ADDR_SLOT_SELECT, 32'h333);
        apb(1, `ADDR_IRQ_MASK, 32'h3);
        @(posedge mclk);
        chk({irq, slot_on}, 32'hF);
        rst <= 1;
        repeat (2) @(posedge mclk);
        chk({irq, slot_on}, 32'h0);
        rst <= 0;
        repeat (2) @(posedge mclk);
        chk({irq, slot_on}, 32'h2);
        apb(0, `ADDR_IRQ_MASK, 0);
        chk(rd, 32'h0);
        $display("reset rerun done");
        stop_test;
    end
endmodule // torque_flag_output_router_tb
bind torque_flag_output_router torque_flag_props u_props (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .torque_reference, .slot_out_n);
